// *** hdl/eiap_ctrl.sv ***
// NVM erase/program and boot-upgrade controller on the SFR and secondary buses.
`include "eiap_defs.svh"
module eiap_ctrl
  import eiap_pkg::*;
#(
  parameter int unsigned PROG_CYCLES  = 32'(`EIAP_NS_TO_CYC(`EIAP_PROG_TIME_NS)),
  parameter int unsigned STEP_CYCLES  = 32'(`EIAP_NS_TO_CYC(`EIAP_ERASE_STEP_NS)),
  parameter int unsigned EXTRA_CYCLES = 32'(`EIAP_NS_TO_CYC(`EIAP_ERASE_EXTRA_NS)),
  parameter int unsigned LONG_CYCLES  = 32'(`EIAP_NS_TO_CYC(`EIAP_ERASE_LONG_NS)),
  parameter bit          BOOT_PRESENT = 1'b1
)
(
  input  wire logic        CLK_I,
  input  wire logic        SRST_I,
  input  wire logic        SFR_WR_I,
  input  wire logic [7:0]  SFR_ADDR_I,
  input  wire logic [7:0]  SFR_WDATA_I,
  output logic [7:0]       SFR_RDATA_O,
  input  wire logic        SEC_WR_I,
  input  wire logic [7:0]  SEC_ADDR_I,
  input  wire logic [7:0]  SEC_WDATA_I,
  output logic [7:0]       SEC_RDATA_O,
  input  wire logic [15:0] PC_I,
  output logic [15:0]      FETCH_ADDR_O,
  output logic             CORE_CLK_EN_O,
  output logic             NVM_ERASE_O,
  output logic             NVM_PROG_O,
  output logic [15:0]      NVM_ADDR_O,
  output logic [7:0]       NVM_WDATA_O,
  output logic             NVM_FLASH_SEL_O,
  output logic             BOOT_MODE_O
);
  // The four five-byte sequences, first byte in the top lane. Entry and exit are watched on the
  // command register and region jumps on the secondary jump register. Keeping them as constants
  // lets one generic detector serve both registers.
  localparam logic [39:0] SEQ_ENTER = 40'h12_34_56_78_9a;
  localparam logic [39:0] SEQ_LEAVE = 40'hfe_dc_ba_98_76;
  localparam logic [39:0] SEQ_APP   = 40'hff_00_88_55_aa;
  localparam logic [39:0] SEQ_BOOT  = 40'h37_c8_42_9a_65;

  // Software-visible registers on both buses.
  logic [7:0]  addr_high_reg, addr_high_next;
  logic [7:0]  addr_low_reg, addr_low_next;
  logic [7:0]  wdata_reg, wdata_next;
  logic [7:0]  cmd_reg, cmd_next;
  logic [7:0]  timing_reg, timing_next;
  logic [7:0]  jump_reg, jump_next;
  logic [15:0] offset_reg, offset_next;
  logic        boot_reg, boot_next;

  // Operation sequencer and the captured target of the running operation.
  eiap_state_t state_reg, state_next;
  logic [31:0] count_reg, count_next;
  logic        clk_en_reg, clk_en_next;
  logic        erase_reg, erase_next;
  logic        prog_reg, prog_next;
  logic [15:0] nvm_addr_reg, nvm_addr_next;
  logic [7:0]  nvm_data_reg, nvm_data_next;
  logic        flash_sel_reg, flash_sel_next;
  logic [15:0] fetch_reg, fetch_next;
  logic [7:0]  sfr_rd_reg, sfr_rd_next;
  logic [7:0]  sec_rd_reg, sec_rd_next;

  // Decoded write strobes and one-cycle sequence hits.
  logic        cmd_wr;
  logic        jump_wr;
  logic        hit_enter;
  logic        hit_leave;
  logic        hit_app;
  logic        hit_boot;

  // Writes to the two registers whose byte streams carry sequences.
  assign cmd_wr  = SFR_WR_I && (SFR_ADDR_I == `EIAP_SFR_CMD);
  assign jump_wr = SEC_WR_I && (SEC_ADDR_I == `EIAP_SEC_JUMP_CMD);

  // Boot-mode entry and exit sequences watched on the command register.
  // The detector sees every command byte, so an erase or program code in the
  // middle of a sequence breaks it and software has to start over.
  eiap_seq_det u_mode_seq (
    .clk_i   (CLK_I),
    .srst_i  (SRST_I),
    .wr_i    (cmd_wr),
    .data_i  (SFR_WDATA_I),
    .seq_a_i (SEQ_ENTER),
    .seq_b_i (SEQ_LEAVE),
    .hit_a_o (hit_enter),
    .hit_b_o (hit_leave)
  );

  // Region jump sequences watched on the secondary jump register.
  // Other secondary registers do not disturb a jump sequence in progress.
  eiap_seq_det u_jump_seq (
    .clk_i   (CLK_I),
    .srst_i  (SRST_I),
    .wr_i    (jump_wr),
    .data_i  (SEC_WDATA_I),
    .seq_a_i (SEQ_APP),
    .seq_b_i (SEQ_BOOT),
    .hit_a_o (hit_app),
    .hit_b_o (hit_boot)
  );

  // Erase length in cycles from the five-bit timing field.
  // The field is read only when the erase starts, so a later write to it
  // cannot stretch or cut an erase that is already running.
  function automatic logic [31:0] erase_cycles(input logic [4:0] f);
    if (f > `EIAP_ERASE_MAX_STEP)
      erase_cycles = LONG_CYCLES;
    else
      erase_cycles = 32'(STEP_CYCLES * (32'(f) + 32'd1) + EXTRA_CYCLES);
  endfunction : erase_cycles

  // Code flash is the target only in boot mode with the data-select bit low.
  function automatic logic flash_target(input logic [7:0] hi, input logic boot);
    flash_target = boot && !hi[`EIAP_BIT_EE_SEL];
  endfunction : flash_target

  // Physical target address of the current address registers.
  function automatic logic [15:0] target_addr(input logic [7:0] hi, input logic [7:0] lo,
                                              input logic boot);
    logic [15:0] base;
    logic [8:0]  in_page_byte_address;
    base = hi[`EIAP_BIT_PAGE_SEL] ? `EIAP_PAGE1_BASE : `EIAP_PAGE0_BASE;
    in_page_byte_address = {hi[`EIAP_BIT_ADDR8], lo};
    if (flash_target(hi, boot))
      target_addr = {1'b0, hi[6:0], lo};
    else
      target_addr = base | {7'h00, in_page_byte_address};
  endfunction : target_addr

  // Register writes, mode and offset updates.
  // Writes land whether or not an operation runs; the core is stalled then,
  // so in practice nothing reaches these registers mid-operation.
  always_comb
  begin
    addr_high_next = addr_high_reg;
    addr_low_next  = addr_low_reg;
    wdata_next     = wdata_reg;
    cmd_next       = cmd_reg;
    timing_next    = timing_reg;
    jump_next      = jump_reg;
    offset_next    = offset_reg;
    boot_next      = boot_reg;
    if (SFR_WR_I)
    begin
      unique case (SFR_ADDR_I)
        `EIAP_SFR_ADDR_HIGH: addr_high_next = SFR_WDATA_I;
        `EIAP_SFR_ADDR_LOW:  addr_low_next  = SFR_WDATA_I;
        `EIAP_SFR_WDATA:     wdata_next     = SFR_WDATA_I;
        `EIAP_SFR_CMD:       cmd_next       = SFR_WDATA_I;
        `EIAP_SFR_TIMING:    timing_next    = SFR_WDATA_I;
        default:             ;
      endcase
    end
    if (jump_wr)
      jump_next = SEC_WDATA_I;
    // Entry and exit differ in every byte, so both can never hit in one cycle.
    if (hit_enter)
      boot_next = 1'b1;
    else if (hit_leave)
      boot_next = 1'b0;
    // Without a boot region the application offset stays zero.
    if (hit_app && BOOT_PRESENT)
      offset_next = `EIAP_APP_OFFSET;
    else if (hit_boot)
      offset_next = 16'h0000;
  end

  // Operation sequencer: start on a command code, hold the core clock off until done.
  // Limitation: the block does not check that a byte was erased before it is
  // programmed; keeping to erase-then-write-once stays with software.
  always_comb
  begin
    state_next     = state_reg;
    count_next     = count_reg;
    clk_en_next    = clk_en_reg;
    erase_next     = erase_reg;
    prog_next      = prog_reg;
    nvm_addr_next  = nvm_addr_reg;
    nvm_data_next  = nvm_data_reg;
    flash_sel_next = flash_sel_reg;
    unique case (state_reg)
      EIAP_IDLE:
      begin
        // Page erase: the low address byte is dropped, so the whole page is
        // cleared even if software left a non-zero byte address behind.
        if (cmd_wr && (SFR_WDATA_I == `EIAP_CMD_ERASE))
        begin
          state_next     = EIAP_ERASE;
          count_next     = erase_cycles(timing_reg[4:0]) - 32'd1;
          clk_en_next    = 1'b0;
          erase_next     = 1'b1;
          nvm_addr_next  = target_addr(addr_high_reg, 8'h00, boot_reg) & 16'hfe00;
          flash_sel_next = flash_target(addr_high_reg, boot_reg);
        end
        // Byte program: target and data are captured so later writes cannot disturb the cell.
        else if (cmd_wr && (SFR_WDATA_I == `EIAP_CMD_PROGRAM))
        begin
          state_next     = EIAP_PROGRAM;
          count_next     = PROG_CYCLES - 32'd1;
          clk_en_next    = 1'b0;
          prog_next      = 1'b1;
          nvm_addr_next  = target_addr(addr_high_reg, addr_low_reg, boot_reg);
          nvm_data_next  = wdata_reg;
          flash_sel_next = flash_target(addr_high_reg, boot_reg);
        end
        // Any other byte leaves the sequencer idle.
      end
      EIAP_ERASE, EIAP_PROGRAM:
      begin
        // The core clock returns on the edge at which the strobe drops, so the
        // core never runs while a cell is still being written.
        if (count_reg == 32'd0)
        begin
          state_next  = EIAP_IDLE;
          clk_en_next = 1'b1;
          erase_next  = 1'b0;
          prog_next   = 1'b0;
        end
        else
          count_next = count_reg - 32'd1;
      end
      // An illegal code returns to idle with the clock running, so the core is never stuck.
      default:
      begin
        state_next  = EIAP_IDLE;
        clk_en_next = 1'b1;
        erase_next  = 1'b0;
        prog_next   = 1'b0;
      end
    endcase
  end

  // Read data and fetch address, registered so every output comes from a flip-flop.
  // Read data thus trails the address by one cycle, and reads have no side effects.
  // Unmapped addresses read zero so no neighbour's register can alias here.
  always_comb
  begin
    fetch_next = 16'(PC_I + offset_reg);
    unique case (SFR_ADDR_I)
      `EIAP_SFR_ADDR_HIGH: sfr_rd_next = addr_high_reg;
      `EIAP_SFR_ADDR_LOW:  sfr_rd_next = addr_low_reg;
      `EIAP_SFR_WDATA:     sfr_rd_next = wdata_reg;
      `EIAP_SFR_CMD:       sfr_rd_next = cmd_reg;
      `EIAP_SFR_TIMING:    sfr_rd_next = timing_reg;
      default:             sfr_rd_next = 8'h00;
    endcase
    unique case (SEC_ADDR_I)
      `EIAP_SEC_BOOT_STAT: sec_rd_next = {7'h00, boot_reg};
      `EIAP_SEC_JUMP_CMD:  sec_rd_next = jump_reg;
      `EIAP_SEC_OFS_LOW:   sec_rd_next = offset_reg[7:0];
      `EIAP_SEC_OFS_HIGH:  sec_rd_next = offset_reg[15:8];
      default:             sec_rd_next = 8'h00;
    endcase
  end

  // All state registers, cleared by system reset except the core clock enable, which is set, and the timing register.
  // The timing register comes out of reset at its preset erase length. A reset
  // in the middle of an operation drops the strobe and returns the core clock at once.
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      addr_high_reg <= 8'h00;
      addr_low_reg  <= 8'h00;
      wdata_reg     <= 8'h00;
      cmd_reg       <= 8'h00;
      timing_reg    <= `EIAP_TIMING_RESET;
      jump_reg      <= 8'h00;
      offset_reg    <= 16'h0000;
      boot_reg      <= 1'b0;
      state_reg     <= EIAP_IDLE;
      count_reg     <= 32'd0;
      clk_en_reg    <= 1'b1;
      erase_reg     <= 1'b0;
      prog_reg      <= 1'b0;
      nvm_addr_reg  <= 16'h0000;
      nvm_data_reg  <= 8'h00;
      flash_sel_reg <= 1'b0;
      fetch_reg     <= 16'h0000;
      sfr_rd_reg    <= 8'h00;
      sec_rd_reg    <= 8'h00;
    end
    else
    begin
      addr_high_reg <= addr_high_next;
      addr_low_reg  <= addr_low_next;
      wdata_reg     <= wdata_next;
      cmd_reg       <= cmd_next;
      timing_reg    <= timing_next;
      jump_reg      <= jump_next;
      offset_reg    <= offset_next;
      boot_reg      <= boot_next;
      state_reg     <= state_next;
      count_reg     <= count_next;
      clk_en_reg    <= clk_en_next;
      erase_reg     <= erase_next;
      prog_reg      <= prog_next;
      nvm_addr_reg  <= nvm_addr_next;
      nvm_data_reg  <= nvm_data_next;
      flash_sel_reg <= flash_sel_next;
      fetch_reg     <= fetch_next;
      sfr_rd_reg    <= sfr_rd_next;
      sec_rd_reg    <= sec_rd_next;
    end
  end

  // Outputs straight from flip-flops.
  // No output passes through logic, so none of them can glitch between edges.
  assign SFR_RDATA_O     = sfr_rd_reg;
  assign SEC_RDATA_O     = sec_rd_reg;
  assign FETCH_ADDR_O    = fetch_reg;
  assign CORE_CLK_EN_O   = clk_en_reg;
  assign NVM_ERASE_O     = erase_reg;
  assign NVM_PROG_O      = prog_reg;
  assign NVM_ADDR_O      = nvm_addr_reg;
  assign NVM_WDATA_O     = nvm_data_reg;
  assign NVM_FLASH_SEL_O = flash_sel_reg;
  assign BOOT_MODE_O     = boot_reg;
endmodule : eiap_ctrl

// *** hdl/eiap_defs.svh ***
// Register offsets, reset values, command codes and timing figures of the NVM access block.
`ifndef EIAP_DEFS_SVH
`define EIAP_DEFS_SVH
`define EIAP_SFR_ADDR_HIGH   8'hf9
`define EIAP_SFR_ADDR_LOW    8'hfa
`define EIAP_SFR_WDATA       8'hfb
`define EIAP_SFR_CMD         8'hfc
`define EIAP_SFR_TIMING      8'hfd
`define EIAP_SEC_BOOT_STAT   8'h21
`define EIAP_SEC_JUMP_CMD    8'h22
`define EIAP_SEC_OFS_LOW     8'h23
`define EIAP_SEC_OFS_HIGH    8'h24
`define EIAP_TIMING_RESET    8'h5a
`define EIAP_CMD_ERASE       8'h96
`define EIAP_CMD_PROGRAM     8'h69
`define EIAP_PAGE0_BASE      16'h8400
`define EIAP_PAGE1_BASE      16'h8600
`define EIAP_APP_OFFSET      16'h1000
`define EIAP_BIT_PAGE_SEL    2
`define EIAP_BIT_ADDR8       0
`define EIAP_BIT_EE_SEL      7
`define EIAP_ERASE_MAX_STEP  5'd9
`define EIAP_CLK_HZ          20000000
`define EIAP_PROG_TIME_NS    23500
`define EIAP_ERASE_STEP_NS   500000
`define EIAP_ERASE_EXTRA_NS  65000
`define EIAP_ERASE_LONG_NS   4565200
`define EIAP_NS_TO_CYC(t)    (((t) * 64'd20) / 64'd1000)
`endif

// *** hdl/eiap_pkg.sv ***
// Types shared by the NVM access block.
package eiap_pkg;
  typedef enum logic [1:0] {EIAP_IDLE, EIAP_ERASE, EIAP_PROGRAM} eiap_state_t;
  typedef logic [2:0] eiap_seq_idx_t;
endpackage : eiap_pkg

// *** hdl/eiap_seq_det.sv ***
// Five-byte command sequence detector with two target sequences.
module eiap_seq_det
  import eiap_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        wr_i,
  input  wire logic [7:0]  data_i,
  input  wire logic [39:0] seq_a_i,
  input  wire logic [39:0] seq_b_i,
  output logic             hit_a_o,
  output logic             hit_b_o
);
  eiap_seq_idx_t idx_a_reg, idx_a_next, idx_b_reg, idx_b_next;
  logic          hit_a_reg, hit_a_next, hit_b_reg, hit_b_next;

  // Expected byte at a position, first byte in the top lane.
  function automatic logic [7:0] seq_byte(input logic [39:0] s, input eiap_seq_idx_t i);
    seq_byte = s[8'(39 - 8 * i) -: 8];
  endfunction : seq_byte

  // A wrong byte restarts the sequence, though it may itself be a first byte.
  function automatic eiap_seq_idx_t step(input logic [39:0] s, input eiap_seq_idx_t i,
                                         input logic [7:0] d);
    if (d == seq_byte(s, i))
      step = (i == 3'd4) ? 3'd0 : 3'(i + 3'd1);
    else if (d == seq_byte(s, 3'd0))
      step = 3'd1;
    else
      step = 3'd0;
  endfunction : step

  // Next index and one-cycle hit pulses.
  always_comb
  begin
    idx_a_next = idx_a_reg;
    idx_b_next = idx_b_reg;
    hit_a_next = 1'b0;
    hit_b_next = 1'b0;
    if (wr_i)
    begin
      idx_a_next = step(seq_a_i, idx_a_reg, data_i);
      idx_b_next = step(seq_b_i, idx_b_reg, data_i);
      hit_a_next = (idx_a_reg == 3'd4) && (data_i == seq_byte(seq_a_i, 3'd4));
      hit_b_next = (idx_b_reg == 3'd4) && (data_i == seq_byte(seq_b_i, 3'd4));
    end
  end

  // Registers only.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      idx_a_reg <= 3'd0;
      idx_b_reg <= 3'd0;
      hit_a_reg <= 1'b0;
      hit_b_reg <= 1'b0;
    end
    else
    begin
      idx_a_reg <= idx_a_next;
      idx_b_reg <= idx_b_next;
      hit_a_reg <= hit_a_next;
      hit_b_reg <= hit_b_next;
    end
  end

  assign hit_a_o = hit_a_reg;
  assign hit_b_o = hit_b_reg;
endmodule : eiap_seq_det

// *** sim/eiap_core_model.sv ***
// Processor-side model that issues cycles on the SFR and secondary buses.
module eiap_core_model
(
  input  wire logic       clk_i,
  input  wire logic [7:0] sfr_rdata_i,
  input  wire logic [7:0] sec_rdata_i,
  output logic            sfr_wr_o,
  output logic [7:0]      sfr_addr_o,
  output logic [7:0]      sfr_wdata_o,
  output logic            sec_wr_o,
  output logic [7:0]      sec_addr_o,
  output logic [7:0]      sec_wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Both buses idle at time zero.
  initial
  begin
    {sfr_wr_o, sfr_addr_o, sfr_wdata_o} = 17'h0;
    {sec_wr_o, sec_addr_o, sec_wdata_o} = 17'h0;
  end

  // One write strobe, then the data lines show the inverse so stale data never looks valid.
  task automatic bus_wr(input bit sec, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {sec_wr_o, sec_addr_o, sec_wdata_o} = sec ? {1'b1, a, d} : {1'b0, sec_addr_o, sec_wdata_o};
    {sfr_wr_o, sfr_addr_o, sfr_wdata_o} = sec ? {1'b0, sfr_addr_o, sfr_wdata_o} : {1'b1, a, d};
    @(negedge clk_i);
    sfr_wr_o    = 1'b0;
    sec_wr_o    = 1'b0;
    sfr_wdata_o = ~sfr_wdata_o;
    sec_wdata_o = ~sec_wdata_o;
  endtask : bus_wr

  // Read data is registered, so it is taken one cycle after the address.
  task automatic bus_rd(input bit sec, input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    if (sec)
      sec_addr_o = a;
    else
      sfr_addr_o = a;
    @(negedge clk_i);
    d = sec ? sec_rdata_i : sfr_rdata_i;
  endtask : bus_rd
endmodule : eiap_core_model

// *** sim/eiap_ctrl_props.sv ***
// Concurrent checks on the ports of the NVM access block.
module eiap_ctrl_props
#(
  parameter int unsigned PROG_CYCLES  = 5,
  parameter int unsigned STEP_CYCLES  = 10,
  parameter int unsigned EXTRA_CYCLES = 3,
  parameter int unsigned LONG_CYCLES  = 40
)
(
  input wire logic        CLK_I,
  input wire logic        SRST_I,
  input wire logic        SFR_WR_I,
  input wire logic [7:0]  SFR_ADDR_I,
  input wire logic [7:0]  SFR_WDATA_I,
  input wire logic [15:0] PC_I,
  input wire logic [15:0] FETCH_ADDR_O,
  input wire logic        CORE_CLK_EN_O,
  input wire logic        NVM_ERASE_O,
  input wire logic        NVM_PROG_O,
  input wire logic [15:0] NVM_ADDR_O,
  input wire logic        NVM_FLASH_SEL_O,
  input wire logic        BOOT_MODE_O
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] op_cnt_reg;
  logic [31:0] op_cnt_next;
  logic [7:0]  tim_reg;
  logic [7:0]  tim_next;
  logic [31:0] erase_len;

  // Length of the running operation and a shadow of the timing register.
  always_comb
  begin
    op_cnt_next = (NVM_ERASE_O || NVM_PROG_O) ? op_cnt_reg + 32'h1 : 32'h0;
    tim_next    = (SFR_WR_I && SFR_ADDR_I == 8'hfd) ? SFR_WDATA_I : tim_reg;
  end
  always_ff @(posedge CLK_I)
  begin
    op_cnt_reg <= SRST_I ? 32'h0 : op_cnt_next;
    tim_reg    <= SRST_I ? 8'h5a : tim_next;
  end
  // Assumes the timing register is left alone while an erase runs.
  assign erase_len = (tim_reg[4:0] > 5'h9) ? LONG_CYCLES
                   : STEP_CYCLES * (32'(tim_reg[4:0]) + 32'h1) + EXTRA_CYCLES;

  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);

  erase_start_a: assert property (SFR_WR_I && SFR_ADDR_I == 8'hfc && SFR_WDATA_I == 8'h96
    && CORE_CLK_EN_O |=> NVM_ERASE_O && !CORE_CLK_EN_O) else $error("erase did not start");
  prog_start_a: assert property (SFR_WR_I && SFR_ADDR_I == 8'hfc && SFR_WDATA_I == 8'h69
    && CORE_CLK_EN_O |=> NVM_PROG_O && !NVM_ERASE_O) else $error("program did not start");
  clock_gate_a: assert property (CORE_CLK_EN_O == !(NVM_ERASE_O || NVM_PROG_O))
    else $error("core clock not gated to the operation");
  prog_length_a: assert property ($fell(NVM_PROG_O) |-> op_cnt_reg == PROG_CYCLES)
    else $error("program length wrong");
  erase_length_a: assert property ($fell(NVM_ERASE_O) |-> op_cnt_reg == erase_len)
    else $error("erase length wrong");
  unknown_cmd_a: assert property (SFR_WR_I && SFR_ADDR_I == 8'hfc && CORE_CLK_EN_O
    && !(SFR_WDATA_I inside {8'h96, 8'h69}) |=> CORE_CLK_EN_O) else $error("stray start");
  boot_enter_a: assert property ($rose(BOOT_MODE_O) |-> $past(SFR_WR_I, 2)
    && $past(SFR_ADDR_I, 2) == 8'hfc && $past(SFR_WDATA_I, 2) == 8'h9a) else $error("bad entry");
  boot_exit_a: assert property ($fell(BOOT_MODE_O) |-> $past(SFR_WR_I, 2)
    && $past(SFR_ADDR_I, 2) == 8'hfc && $past(SFR_WDATA_I, 2) == 8'h76) else $error("bad exit");
  page_addr_a: assert property ($rose(NVM_PROG_O) && !NVM_FLASH_SEL_O
    |-> NVM_ADDR_O[15:10] == 6'h21) else $error("program outside data pages");
  erase_base_a: assert property ($rose(NVM_ERASE_O) && !NVM_FLASH_SEL_O
    |-> NVM_ADDR_O inside {16'h8400, 16'h8600}) else $error("erase not at a page base");
  fetch_offset_a: assert property (!$past(SRST_I)
    |-> (FETCH_ADDR_O - $past(PC_I)) inside {16'h0, 16'h1000})
    else $error("fetch address offset wrong");
endmodule : eiap_ctrl_props

bind eiap_ctrl eiap_ctrl_props #(.PROG_CYCLES(PROG_CYCLES), .STEP_CYCLES(STEP_CYCLES),
  .EXTRA_CYCLES(EXTRA_CYCLES), .LONG_CYCLES(LONG_CYCLES)) u_props (.CLK_I(CLK_I),
  .SRST_I(SRST_I), .SFR_WR_I(SFR_WR_I), .SFR_ADDR_I(SFR_ADDR_I), .SFR_WDATA_I(SFR_WDATA_I),
  .PC_I(PC_I), .FETCH_ADDR_O(FETCH_ADDR_O), .CORE_CLK_EN_O(CORE_CLK_EN_O),
  .NVM_ERASE_O(NVM_ERASE_O), .NVM_PROG_O(NVM_PROG_O), .NVM_ADDR_O(NVM_ADDR_O),
  .NVM_FLASH_SEL_O(NVM_FLASH_SEL_O), .BOOT_MODE_O(BOOT_MODE_O));

// *** sim/eiap_ctrl_test.sv ***
// Self-checking bench of the NVM access block against a bench-side model.
module eiap_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int P = 5, S = 10, X = 3, L = 40;
  logic        clk, srst, sfr_wr, sec_wr, clk_en, erase, prog, fsel, boot;
  logic [15:0] pc, fetch, nvm_addr;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, sec_addr, sec_wdata, sec_rdata, nvm_wdata;
  int          miscompares, check_count, ofs, sfr_m[256], sec_m[256];

  eiap_core_model u_core (.clk_i(clk), .sfr_rdata_i(sfr_rdata), .sec_rdata_i(sec_rdata),
    .sfr_wr_o(sfr_wr), .sfr_addr_o(sfr_addr), .sfr_wdata_o(sfr_wdata),
    .sec_wr_o(sec_wr), .sec_addr_o(sec_addr), .sec_wdata_o(sec_wdata));
  eiap_ctrl #(.PROG_CYCLES(P), .STEP_CYCLES(S), .EXTRA_CYCLES(X), .LONG_CYCLES(L)) u_dut (
    .CLK_I(clk), .SRST_I(srst), .SFR_WR_I(sfr_wr), .SFR_ADDR_I(sfr_addr),
    .SFR_WDATA_I(sfr_wdata), .SFR_RDATA_O(sfr_rdata), .SEC_WR_I(sec_wr), .SEC_ADDR_I(sec_addr),
    .SEC_WDATA_I(sec_wdata), .SEC_RDATA_O(sec_rdata), .PC_I(pc), .FETCH_ADDR_O(fetch),
    .CORE_CLK_EN_O(clk_en), .NVM_ERASE_O(erase), .NVM_PROG_O(prog), .NVM_ADDR_O(nvm_addr),
    .NVM_WDATA_O(nvm_wdata), .NVM_FLASH_SEL_O(fsel), .BOOT_MODE_O(boot));

  // System clock at 20 MHz.
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic test_done();
    if (miscompares == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Writes keep the register model in step with the design.
  task automatic wr(input bit sec, input logic [7:0] a, input logic [7:0] d);
    u_core.bus_wr(sec, a, d);
    if (sec)
      sec_m[a] = d;
    else
      sfr_m[a] = d;
  endtask : wr

  task automatic chkrd(input bit sec, input logic [7:0] a);
    logic [7:0] v;
    u_core.bus_rd(sec, a, v);
    chk(v, sec ? sec_m[a] : sfr_m[a]);
  endtask : chkrd

  // Reset values, unmapped neighbours on both buses included.
  task automatic regs();
    for (int a = 8'hf8; a <= 8'hfe; a++)
      chkrd(1'b0, 8'(a));
    for (int a = 8'h20; a <= 8'h25; a++)
      chkrd(1'b1, 8'(a));
  endtask : regs

  task automatic reset();
    srst = 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    foreach (sfr_m[i]) sfr_m[i] = 0;
    foreach (sec_m[i]) sec_m[i] = 0;
    sfr_m[8'hfd] = 8'h5a;
    ofs = 0;
  endtask : reset

  task automatic fchk();
    @(negedge clk);
    pc = 16'($urandom);
    @(negedge clk);
    chk(fetch, pc + 16'(ofs));
  endtask : fchk

  task automatic seq(input bit sec, input logic [39:0] s);
    for (int k = 4; k >= 0; k--)
      wr(sec, sec ? 8'h22 : 8'hfc, s[8*k +: 8]);
  endtask : seq

  // Starts one command, then times the stall until the core clock returns.
  task automatic op(input logic [7:0] c, input int len, input logic [15:0] adr,
                    input logic [7:0] dat, input logic fs);
    int n;
    n = 0;
    wr(1'b0, 8'hfc, c); // the core model issues nothing while stalled
    chk({erase, prog, clk_en, fsel}, {c == 8'h96, c == 8'h69, 1'b0, fs});
    chk(nvm_addr, adr);
    if (c == 8'h69)
      chk(nvm_wdata, dat);
    while (!clk_en && n < 5000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 5000)
    begin
      miscompares++; // A stall that never ends counts as a mismatch.
      test_done();
    end
    chk(n, len);
  endtask : op

  // Register offsets, erase timing steps and the two jump sequences used below.
  logic [7:0]  ra[4] = '{8'hf9, 8'hfa, 8'hfb, 8'hfd};
  int          ft[4] = '{0, 9, 10, 26};
  logic [39:0] js[2] = '{40'hff008855aa, 40'h37c8429a65};

  initial
  begin
    logic [7:0]  h, l, d;
    pc = 16'h0;
    void'($urandom(32'he607df42));
    reset();
    regs();
    fchk();
    foreach (ra[i])
    begin
      wr(1'b0, ra[i], 8'($urandom));
      chkrd(1'b0, ra[i]);
    end
    // Each data page is erased before any byte of it is programmed.
    foreach (ft[i])
    begin
      wr(1'b0, 8'hfd, {3'($urandom), 5'(ft[i])});
      wr(1'b0, 8'hfa, 8'h00);
      wr(1'b0, 8'hf9, {5'h0, i[0], 2'h0});
      op(8'h96, ft[i] > 9 ? L : S * (ft[i] + 1) + X, i[0] ? 16'h8600 : 16'h8400, 8'h0, 1'b0);
    end
    for (int i = 0; i < 4; i++)
    begin
      {h, l, d} = 24'($urandom);
      h[2] = i[0];
      if (i == 3)
        {h[0], l} = 9'h1ff;
      wr(1'b0, 8'hf9, h);
      wr(1'b0, 8'hfa, l);
      wr(1'b0, 8'hfb, d);
      op(8'h69, P, {6'h21, h[2], h[0], l}, d, 1'b0);
    end
    wr(1'b0, 8'hf9, 8'h00);
    wr(1'b0, 8'hfa, 8'h00);
    wr(1'b0, 8'hfc, 8'h55);
    chk({erase, prog, clk_en, boot}, 4'h2);
    seq(1'b0, 40'h1234991234);
    seq(1'b0, 40'h123456789a);
    chk(boot, 1'b0);
    repeat (2) @(negedge clk);
    chk(boot, 1'b1);
    sec_m[8'h21] = 1;
    chkrd(1'b1, 8'h21);
    {h, l, d} = 24'($urandom);
    h[7] = 1'b0;
    wr(1'b0, 8'hf9, h);
    wr(1'b0, 8'hfa, l);
    wr(1'b0, 8'hfb, d);
    op(8'h69, P, {1'b0, h[6:0], l}, d, 1'b1);
    h[7] = 1'b1;
    wr(1'b0, 8'hf9, h);
    op(8'h69, P, {6'h21, h[2], h[0], l}, d, 1'b0);
    seq(1'b0, 40'hfedcba9876);
    repeat (2) @(negedge clk);
    chk(boot, 1'b0);
    sec_m[8'h21] = 0;
    chkrd(1'b1, 8'h21);
    foreach (js[i])
    begin
      seq(1'b1, js[i]);
      ofs = i ? 0 : 16'h1000;
      sec_m[8'h23] = ofs & 8'hff;
      sec_m[8'h24] = ofs >> 8;
      repeat (3) @(negedge clk);
      chkrd(1'b1, 8'h22);
      chkrd(1'b1, 8'h23);
      chkrd(1'b1, 8'h24);
      fchk();
    end
    seq(1'b1, js[0]);
    wr(1'b0, 8'hfc, 8'h96);
    repeat (5) @(negedge clk);
    reset();
    chk({erase, prog, clk_en, boot}, 4'h2);
    regs();
    fchk();
    test_done();
  end
endmodule : eiap_ctrl_test
